//--- rtl/adcr_pkg.sv
// shared constants for the converter control register bank
package adcr_pkg;
	localparam logic [31:0] ADCR_BASE_ADDR = 32'h4080_0000;
	localparam logic [31:0] ADCR_BASE_MASK = 32'hffff_f000;
	localparam logic [11:0] OFF_CONTROL = 12'h000;
	localparam logic [11:0] OFF_SETTINGS = 12'h004;
	localparam logic [11:0] OFF_MASKED = 12'h008;
	localparam logic [11:0] OFF_MASK = 12'h00c;
	localparam logic [11:0] OFF_RAW = 12'h010;
	localparam logic [11:0] OFF_RESULT = 12'h014;
	localparam logic [11:0] OFF_OFFSET = 12'h018;
	localparam logic [11:0] OFF_STATUS = 12'h020;
	localparam logic [11:0] OFF_UPPER = 12'h024;
	localparam logic [11:0] OFF_LOWER = 12'h028;
	localparam logic [31:0] RST_SETTINGS = 32'h0000_000c;
	localparam logic [31:0] RST_MASK = 32'h0000_000f;
	localparam logic [31:0] RST_UPPER = 32'h0fff_ffff;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	// control register bits
	localparam int CB_POWER_ON = 0;
	localparam int CB_CAL_EN = 1;
	localparam int CB_START = 2;
	localparam int CB_SOFT_RESET = 3;
	localparam int CB_STOP = 4;
	localparam int CB_WIN_EN = 5;
	localparam int CB_CAL_DIS = 6;
	localparam int CB_AUTO_OFS = 7;
	localparam int CB_MICROPHONE_POWER_ON = 8;
	localparam int CB_DMA_EN = 9;
	// settings fields
	localparam int SB_CONT = 11;
	localparam int SB_SKIP = 18;
	// status and interrupt flag positions
	localparam int ST_BUSY = 0;
	localparam int ST_WIN = 1;
	localparam int FL_CAL_DONE = 0;
	localparam int FL_CONV_DONE = 1;
	localparam int FL_WIN = 2;
	localparam int FLAG_W = 3;
	// wake-up settle time, rounded up to whole cycles
	localparam int WAKE_TIME_NS = 6000;
	localparam int CLK_PERIOD_PS = 8000;
	localparam int WAKE_CYCLES = (WAKE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

//--- rtl/adcr_seq_if.sv
// control and phase signals between the register bank and the sequencer
`timescale 1ns/1ps
`default_nettype none
interface adcr_seq_if;
	logic start;
	logic halt;
	logic cal_en;
	logic cont;
	logic cal_done;
	logic data_valid;
	logic busy;
	logic waking;
	logic cal_run;
	logic acq_run;
	modport ctrl (output start, halt, cal_en, cont, cal_done, data_valid, input busy, waking, cal_run, acq_run);
	modport seq (input start, halt, cal_en, cont, cal_done, data_valid, output busy, waking, cal_run, acq_run);
endinterface
`default_nettype wire

//--- rtl/adcr_seq.sv
// conversion phase sequencer: wake-up, calibration, acquisition
`timescale 1ns/1ps
`default_nettype none
module adcr_seq #(
	parameter int WAKE_CYC = adcr_pkg::WAKE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	adcr_seq_if.seq sif
);
	import adcr_pkg::*;
	localparam int CW = $clog2(WAKE_CYC + 1);
	typedef enum logic [1:0] {SQ_IDLE, SQ_WAKE, SQ_CAL, SQ_ACQ} adcr_state_t;
	adcr_state_t state_r;
	adcr_state_t state_nxt;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic wake_end;
	assign wake_end = (cnt_r == CW'(WAKE_CYC - 1));
	// phase transitions; halt wins over everything
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = '0;
		case (state_r)
			SQ_IDLE: if (sif.start) state_nxt = SQ_WAKE;
			SQ_WAKE: begin
				cnt_nxt = cnt_r + CW'(1);
				if (wake_end) state_nxt = sif.cal_en ? SQ_CAL : SQ_ACQ;
			end
			SQ_CAL: if (sif.cal_done) state_nxt = SQ_ACQ;
			SQ_ACQ: if (sif.data_valid && !sif.cont) state_nxt = SQ_IDLE;
			default: state_nxt = SQ_IDLE;
		endcase
		if (sif.halt) begin
			state_nxt = SQ_IDLE;
			cnt_nxt = '0;
		end
	end
	// state and registered phase outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= SQ_IDLE;
			cnt_r <= '0;
			sif.busy <= 1'b0;
			sif.waking <= 1'b0;
			sif.cal_run <= 1'b0;
			sif.acq_run <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			sif.busy <= (state_nxt != SQ_IDLE);
			sif.waking <= (state_nxt == SQ_WAKE);
			sif.cal_run <= (state_nxt == SQ_CAL);
			sif.acq_run <= (state_nxt == SQ_ACQ);
		end
	end
endmodule // adcr_seq
`default_nettype wire

//--- rtl/adcr_bank.sv
// converter control register bank with peripheral bus slave
`timescale 1ns/1ps
`default_nettype none
module adcr_bank #(
	parameter int WAKE_CYC = adcr_pkg::WAKE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic core_cal_done,
	input wire logic [15:0] core_cal_value,
	input wire logic core_data_valid,
	input wire logic [31:0] core_data,
	output logic analog_power_on,
	output logic microphone_power_on,
	output logic dma_enable,
	output logic dma_request,
	output logic [31:0] settings_out,
	output logic [31:0] offset_out,
	output logic core_wake,
	output logic core_cal_run,
	output logic core_acq_run,
	output logic conversion_busy
);
	import adcr_pkg::*;

	// control fields
	logic power_on_r;
	logic calibration_enable_r;
	logic software_conversion_start_r;
	logic window_compare_enable_r;
	logic auto_offset_r;
	logic microphone_power_on_r;
	logic dma_enable_r;
	// data registers
	logic [31:0] adc_settings_r;
	logic [31:0] interrupt_mask_bits_r;
	logic [FLAG_W-1:0] interrupt_raw_flags_r;
	logic [FLAG_W-1:0] raw_nxt;
	logic [31:0] conversion_result_r;
	logic [31:0] offset_correction_r;
	logic [31:0] offset_nxt;
	logic window_match_flag_r;
	logic [31:0] window_upper_limit_r;
	logic [31:0] window_lower_limit_r;
	logic [31:0] rd_data_r;
	logic dma_req_r;

	adcr_seq_if sif ();

	adcr_seq #(
		.WAKE_CYC(WAKE_CYC)
	) u_seq (
		.clk(clk),
		.rst(rst),
		.sif(sif)
	);

	// address decode relative to the peripheral base
	logic base_hit;
	logic [11:0] off;
	logic hit_ctrl;
	logic hit_set;
	logic hit_masked;
	logic hit_mask;
	logic hit_raw;
	logic hit_res;
	logic hit_ofs;
	logic hit_stat;
	logic hit_up;
	logic hit_lo;
	logic mapped;
	assign base_hit = ((paddr & ADCR_BASE_MASK) == ADCR_BASE_ADDR);
	assign off = paddr[11:0];
	assign hit_ctrl = base_hit && (off == OFF_CONTROL);
	assign hit_set = base_hit && (off == OFF_SETTINGS);
	assign hit_masked = base_hit && (off == OFF_MASKED);
	assign hit_mask = base_hit && (off == OFF_MASK);
	assign hit_raw = base_hit && (off == OFF_RAW);
	assign hit_res = base_hit && (off == OFF_RESULT);
	assign hit_ofs = base_hit && (off == OFF_OFFSET);
	assign hit_stat = base_hit && (off == OFF_STATUS);
	assign hit_up = base_hit && (off == OFF_UPPER);
	assign hit_lo = base_hit && (off == OFF_LOWER);
	assign mapped = hit_ctrl | hit_set | hit_masked | hit_mask | hit_raw | hit_res | hit_ofs | hit_stat | hit_up | hit_lo;

	// bus phases: data is prepared in setup, acted on in access
	logic setup_ph;
	logic access_ph;
	logic wr;
	logic rd_acc;
	assign setup_ph = psel && !penable;
	assign access_ph = psel && penable;
	assign wr = access_ph && pwrite;
	assign rd_acc = access_ph && !pwrite;

	// write strobes; read-only registers have none
	logic wr_ctrl;
	logic wr_set;
	logic wr_mask;
	logic wr_ofs;
	logic wr_stat;
	logic wr_up;
	logic wr_lo;
	assign wr_ctrl = wr && hit_ctrl;
	assign wr_set = wr && hit_set && !sif.busy;
	assign wr_mask = wr && hit_mask;
	assign wr_ofs = wr && hit_ofs;
	assign wr_stat = wr && hit_stat;
	assign wr_up = wr && hit_up;
	assign wr_lo = wr && hit_lo;

	// self-clearing command strobes
	logic soft_reset;
	logic stop_cmd;
	logic cal_disable;
	assign soft_reset = wr_ctrl && pwdata[CB_SOFT_RESET];
	assign stop_cmd = wr_ctrl && pwdata[CB_STOP];
	assign cal_disable = wr_ctrl && pwdata[CB_CAL_DIS];

	// next control values; a plain zero never clears calibration enable
	logic power_on_nxt;
	logic cal_en_nxt;
	logic start_nxt;
	logic win_en_nxt;
	logic auto_ofs_nxt;
	logic mic_nxt;
	logic dma_nxt;
	assign power_on_nxt = wr_ctrl ? pwdata[CB_POWER_ON] : power_on_r;
	assign cal_en_nxt = cal_disable ? 1'b0 : (calibration_enable_r | (wr_ctrl & pwdata[CB_CAL_EN]));
	assign start_nxt = wr_ctrl ? pwdata[CB_START] : software_conversion_start_r;
	assign win_en_nxt = wr_ctrl ? pwdata[CB_WIN_EN] : window_compare_enable_r;
	assign auto_ofs_nxt = wr_ctrl ? pwdata[CB_AUTO_OFS] : auto_offset_r;
	assign mic_nxt = wr_ctrl ? pwdata[CB_MICROPHONE_POWER_ON] : microphone_power_on_r;
	assign dma_nxt = wr_ctrl ? pwdata[CB_DMA_EN] : dma_enable_r;

	// conversion start needs power-on and is not a microphone-mode action
	logic start_req;
	assign start_req = wr_ctrl && pwdata[CB_START] && power_on_nxt && !mic_nxt && !stop_cmd && !soft_reset;

	// sequencer hookup
	assign sif.start = start_req && !sif.busy;
	assign sif.halt = stop_cmd || soft_reset || (wr_ctrl && !pwdata[CB_POWER_ON]);
	assign sif.cal_en = calibration_enable_r && auto_offset_r;
	assign sif.cont = adc_settings_r[SB_CONT];
	assign sif.cal_done = core_cal_done && sif.cal_run;
	assign sif.data_valid = core_data_valid && sif.acq_run;

	// offset compensation and window test on the finished sample
	logic [31:0] compensated;
	logic in_window;
	logic win_hit;
	assign compensated = core_data - offset_correction_r;
	assign in_window = (compensated >= window_lower_limit_r) && (compensated <= window_upper_limit_r);
	assign win_hit = sif.data_valid && window_compare_enable_r && in_window;

	// calibration result lands in the half chosen by the filter bypass
	always_comb begin
		offset_nxt = offset_correction_r;
		if (wr_ofs) begin
			offset_nxt = pwdata;
		end
		if (sif.cal_done) begin
			if (adc_settings_r[SB_SKIP]) begin
				offset_nxt[15:0] = core_cal_value;
			end else begin
				offset_nxt[31:16] = core_cal_value;
			end
		end
	end

	// event flags: a read of the masked view clears the bits it showed, new events win
	logic [FLAG_W-1:0] flag_set;
	logic [FLAG_W-1:0] flag_clr;
	logic rd_masked;
	assign rd_masked = rd_acc && hit_masked;
	assign flag_set = {win_hit, sif.data_valid, sif.cal_done};
	assign flag_clr = rd_masked ? rd_data_r[FLAG_W-1:0] : '0;
	assign raw_nxt = (interrupt_raw_flags_r & ~flag_clr) | flag_set;

	// masked view: a mask bit of one holds its event back
	logic [FLAG_W-1:0] masked_flags;
	assign masked_flags = interrupt_raw_flags_r & ~interrupt_mask_bits_r[FLAG_W-1:0];

	// read values; reserved and command bits read zero
	logic [31:0] ctrl_view;
	logic [31:0] stat_view;
	logic [31:0] rd_mux;
	assign ctrl_view = {22'h0, dma_enable_r, microphone_power_on_r, auto_offset_r, 1'b0, window_compare_enable_r, 2'b00,
		software_conversion_start_r, calibration_enable_r, power_on_r};
	assign stat_view = {30'h0, window_match_flag_r, sif.busy};
	assign rd_mux = hit_ctrl ? ctrl_view :
		hit_set ? adc_settings_r :
		hit_masked ? {{(32-FLAG_W){1'b0}}, masked_flags} :
		hit_mask ? interrupt_mask_bits_r :
		hit_raw ? {{(32-FLAG_W){1'b0}}, interrupt_raw_flags_r} :
		hit_res ? conversion_result_r :
		hit_ofs ? offset_correction_r :
		hit_stat ? stat_view :
		hit_up ? window_upper_limit_r :
		hit_lo ? window_lower_limit_r : RST_ZERO;

	// bus answer registers: ready always high, error on unmapped access
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data_r <= RST_ZERO;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (setup_ph) begin
				rd_data_r <= rd_mux;
				pslverr <= !mapped;
			end
		end
	end

	// control register; soft reset takes priority over a write, stop only over the power, start, microphone and DMA bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			power_on_r <= 1'b0;
			calibration_enable_r <= 1'b0;
			software_conversion_start_r <= 1'b0;
			window_compare_enable_r <= 1'b0;
			auto_offset_r <= 1'b0;
			microphone_power_on_r <= 1'b0;
			dma_enable_r <= 1'b0;
		end else if (soft_reset) begin
			power_on_r <= 1'b0;
			calibration_enable_r <= 1'b0;
			software_conversion_start_r <= 1'b0;
			window_compare_enable_r <= 1'b0;
			auto_offset_r <= 1'b0;
			microphone_power_on_r <= 1'b0;
			dma_enable_r <= 1'b0;
		end else begin
			power_on_r <= power_on_nxt && !stop_cmd;
			calibration_enable_r <= cal_en_nxt;
			software_conversion_start_r <= start_nxt && !stop_cmd;
			window_compare_enable_r <= win_en_nxt;
			auto_offset_r <= auto_ofs_nxt;
			microphone_power_on_r <= mic_nxt && !stop_cmd;
			dma_enable_r <= dma_nxt && !stop_cmd;
		end
	end

	// settings, thresholds and result; soft reset restores them
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			adc_settings_r <= RST_SETTINGS;
			window_upper_limit_r <= RST_UPPER;
			window_lower_limit_r <= RST_ZERO;
			conversion_result_r <= RST_ZERO;
		end else if (soft_reset) begin
			adc_settings_r <= RST_SETTINGS;
			window_upper_limit_r <= RST_UPPER;
			window_lower_limit_r <= RST_ZERO;
			conversion_result_r <= RST_ZERO;
		end else begin
			if (wr_set) adc_settings_r <= pwdata;
			if (wr_up) window_upper_limit_r <= pwdata;
			if (wr_lo) window_lower_limit_r <= pwdata;
			if (sif.data_valid) conversion_result_r <= compensated;
		end
	end

	// mask, offset and event flags keep their values across soft reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			interrupt_mask_bits_r <= RST_MASK;
			offset_correction_r <= RST_ZERO;
			interrupt_raw_flags_r <= '0;
		end else begin
			if (wr_mask) interrupt_mask_bits_r <= pwdata;
			offset_correction_r <= offset_nxt;
			interrupt_raw_flags_r <= raw_nxt;
		end
	end

	// window match status: write one clears, a new match wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			window_match_flag_r <= 1'b0;
		end else begin
			window_match_flag_r <= (window_match_flag_r && !(wr_stat && pwdata[ST_WIN])) || win_hit;
		end
	end

	// one-cycle DMA request per finished result while DMA is enabled
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dma_req_r <= 1'b0;
		end else begin
			dma_req_r <= sif.data_valid && dma_enable_r;
		end
	end

	// core-facing outputs, all from flops
	assign prdata = rd_data_r;
	assign analog_power_on = power_on_r;
	assign microphone_power_on = microphone_power_on_r;
	assign dma_enable = dma_enable_r;
	assign dma_request = dma_req_r;
	assign settings_out = adc_settings_r;
	assign offset_out = offset_correction_r;
	assign core_wake = sif.waking;
	assign core_cal_run = sif.cal_run;
	assign core_acq_run = sif.acq_run;
	assign conversion_busy = sif.busy;
endmodule // adcr_bank
`default_nettype wire

//--- dv/adcr_bank_chk.sv
// assertion checker on the ports of the converter register bank
`timescale 1ns/1ps
`default_nettype none
module adcr_bank_chk #(
	parameter int WAKE_CYC = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic core_cal_done,
	input wire logic core_data_valid,
	input wire logic dma_enable,
	input wire logic dma_request,
	input wire logic [31:0] settings_out,
	input wire logic core_wake,
	input wire logic core_cal_run,
	input wire logic core_acq_run,
	input wire logic conversion_busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic [15:0] wake_cnt_r;
	// length of the current wake-up run
	always_ff @(posedge clk or posedge rst) begin
		if (rst) wake_cnt_r <= 16'h0;
		else wake_cnt_r <= core_wake ? wake_cnt_r + 16'h1 : 16'h0;
	end
	no_wait_states_a: assert property (!$past(rst) |-> pready) else $error("pready low");
	bad_base_err_a: assert property (psel && !penable && paddr[31:12] != 20'h40800 |=> pslverr)
		else $error("foreign address not refused");
	busy_wakes_a: assert property ($rose(conversion_busy) |-> core_wake) else $error("no wake at start");
	wake_length_a: assert property ($fell(core_wake) && conversion_busy |-> wake_cnt_r == 16'(WAKE_CYC))
		else $error("wake interval length wrong");
	cal_in_busy_a: assert property (core_cal_run |-> conversion_busy && !core_wake) else $error("cal outside busy");
	cal_to_acq_a: assert property (core_cal_run && core_cal_done |=> core_acq_run && !core_cal_run)
		else $error("no acquisition after calibration");
	single_ends_a: assert property (core_acq_run && core_data_valid && !settings_out[11] |=> !conversion_busy)
		else $error("single conversion did not end");
	dma_cause_a: assert property (dma_request |-> $past(core_data_valid) && $past(core_acq_run) && $past(dma_enable))
		else $error("dma request without sample");
	// a soft reset may restore the settings in the very cycle that it ends a conversion
	settings_lock_a: assert property ($past(conversion_busy) && conversion_busy |-> $stable(settings_out))
		else $error("settings changed while busy");
endmodule // adcr_bank_chk
bind adcr_bank adcr_bank_chk #(.WAKE_CYC(WAKE_CYC)) chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.paddr(paddr), .pready(pready), .pslverr(pslverr), .core_cal_done(core_cal_done),
	.core_data_valid(core_data_valid), .dma_enable(dma_enable), .dma_request(dma_request),
	.settings_out(settings_out), .core_wake(core_wake), .core_cal_run(core_cal_run),
	.core_acq_run(core_acq_run), .conversion_busy(conversion_busy));
`default_nettype wire

//--- dv/adcr_core_model.sv
// behavioural analog core and filter answering calibration and acquisition phases
`timescale 1ns/1ps
`default_nettype none
module adcr_core_model #(
	parameter int DLY = 3,
	parameter logic [15:0] CAL_VAL = 16'h0003,
	parameter logic [31:0] DATA_VAL = 32'h0000_0100
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cal_run,
	input wire logic acq_run,
	output logic cal_done,
	output logic [15:0] cal_value,
	output logic data_valid,
	output logic [31:0] data
);
	logic [7:0] cnt_r;
	wire logic fire = (cal_run || acq_run) && cnt_r == DLY[7:0];
	// answer each phase after DLY cycles with a one-cycle pulse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 8'h0;
			cal_done <= 1'b0;
			data_valid <= 1'b0;
		end else begin
			cnt_r <= (cal_run || acq_run) && !fire ? cnt_r + 8'h1 : 8'h0;
			cal_done <= fire && cal_run;
			data_valid <= fire && acq_run;
		end
	end
	// values are only meaningful during the pulse, so show garbage otherwise
	assign cal_value = cal_done ? CAL_VAL : ~CAL_VAL;
	assign data = data_valid ? DATA_VAL : ~DATA_VAL;
endmodule // adcr_core_model
`default_nettype wire

//--- dv/test_adc_control_register_bank.sv
// self-checking bench for the converter control register bank
`timescale 1ns/1ps
`default_nettype none
module test_adc_control_register_bank;
	import adcr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	wire logic [31:0] prdata, settings_out, offset_out, core_data;
	wire logic [15:0] core_cal_value;
	wire logic pready, pslverr, core_cal_done, core_data_valid, analog_power_on, microphone_power_on;
	wire logic dma_enable, dma_request, core_wake, core_cal_run, core_acq_run, conversion_busy;
	logic [31:0] rdat;
	logic perr;
	int miscompares = 0;
	int comparisons = 0;
	int dma_seen = 0;
	always #4 clk = ~clk;
	adcr_bank #(.WAKE_CYC(4)) DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.core_cal_done(core_cal_done), .core_cal_value(core_cal_value), .core_data_valid(core_data_valid),
		.core_data(core_data), .analog_power_on(analog_power_on), .microphone_power_on(microphone_power_on),
		.dma_enable(dma_enable), .dma_request(dma_request), .settings_out(settings_out), .offset_out(offset_out),
		.core_wake(core_wake), .core_cal_run(core_cal_run), .core_acq_run(core_acq_run),
		.conversion_busy(conversion_busy));
	adcr_core_model #(.DLY(3)) core (.clk(clk), .rst(rst), .cal_run(core_cal_run), .acq_run(core_acq_run),
		.cal_done(core_cal_done), .cal_value(core_cal_value), .data_valid(core_data_valid), .data(core_data));
	// count dma pulses seen by the far side
	always @(posedge clk) begin
		if (dma_request === 1'b1) dma_seen++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one zero-wait transfer, then an idle cycle
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, ADCR_BASE_ADDR | {20'h0, a}, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, ADCR_BASE_ADDR | {20'h0, a}, 32'h0);
		chk(rdat, exp);
	endtask
	task automatic t_reset_values;
		rd(OFF_CONTROL, 32'h0);
		rd(OFF_SETTINGS, 32'h0000_000c);
		rd(OFF_MASKED, 32'h0);
		rd(OFF_MASK, 32'h0000_000f);
		rd(OFF_RAW, 32'h0);
		rd(OFF_RESULT, 32'h0);
		rd(OFF_OFFSET, 32'h0);
		rd(OFF_STATUS, 32'h0);
		rd(OFF_UPPER, 32'h0fff_ffff);
		rd(OFF_LOWER, 32'h0);
	endtask
	task automatic t_control_bits;
		wr(OFF_CONTROL, 32'hffff_fc02);
		rd(OFF_CONTROL, 32'h0000_0002);
		wr(OFF_CONTROL, 32'h0000_0000);
		rd(OFF_CONTROL, 32'h0000_0002);
		wr(OFF_CONTROL, 32'h0000_0040);
		rd(OFF_CONTROL, 32'h0);
		wr(OFF_CONTROL, 32'h0000_0100);
		chk({31'h0, microphone_power_on}, 32'h1);
		wr(OFF_CONTROL, 32'h0000_0010);
		rd(OFF_CONTROL, 32'h0);
		chk({31'h0, microphone_power_on}, 32'h0);
		bus(1'b0, ADCR_BASE_ADDR | 32'h1c, 32'h0);
		chk({31'h0, perr}, 32'h1);
		bus(1'b0, 32'h4090_0000, 32'h0);
		chk({31'h0, perr}, 32'h1);
	endtask
	task automatic t_conversion;
		int n;
		wr(OFF_OFFSET, 32'h0000_0010);
		wr(OFF_UPPER, 32'hffff_ffff);
		wr(OFF_LOWER, 32'hfffd_0000);
		wr(OFF_CONTROL, 32'h0000_02a7);
		chk({31'h0, analog_power_on}, 32'h1);
		wr(OFF_SETTINGS, 32'h0000_0800);
		rd(OFF_CONTROL, 32'h0000_02a7);
		n = 0;
		while (conversion_busy !== 1'b0 && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk({31'h0, conversion_busy}, 32'h0);
		rd(OFF_SETTINGS, 32'h0000_000c);
		rd(OFF_OFFSET, 32'h0003_0010);
		rd(OFF_RESULT, 32'hfffd_00f0);
		wr(OFF_RESULT, 32'h0000_0055);
		rd(OFF_RESULT, 32'hfffd_00f0);
		rd(OFF_RAW, 32'h0000_0007);
		rd(OFF_STATUS, 32'h0000_0002);
		chk(dma_seen, 32'h1);
		rd(OFF_MASKED, 32'h0);
		wr(OFF_MASK, 32'h0);
		rd(OFF_MASKED, 32'h0000_0007);
		rd(OFF_MASKED, 32'h0);
		wr(OFF_STATUS, 32'h0000_0002);
		rd(OFF_STATUS, 32'h0);
		wr(OFF_CONTROL, 32'h0000_02b7);
		rd(OFF_CONTROL, 32'h0000_00a2);
		chk({30'h0, analog_power_on, dma_enable}, 32'h0);
	endtask
	task automatic t_soft_reset;
		wr(OFF_MASK, 32'h0000_0003);
		wr(OFF_SETTINGS, 32'h0004_000c);
		wr(OFF_CONTROL, 32'h0000_0008);
		rd(OFF_CONTROL, 32'h0);
		rd(OFF_SETTINGS, 32'h0000_000c);
		rd(OFF_RESULT, 32'h0);
		rd(OFF_UPPER, 32'h0fff_ffff);
		rd(OFF_LOWER, 32'h0);
		rd(OFF_MASK, 32'h0000_0003);
		rd(OFF_OFFSET, 32'h0003_0010);
		chk(settings_out, 32'h0000_000c);
	endtask
	// continuous mode with filter bypass: calibration lands in the low half, stop ends the run
	task automatic t_continuous;
		wr(OFF_SETTINGS, 32'h0004_080c);
		wr(OFF_CONTROL, 32'h0000_0087);
		repeat (20) @(posedge clk);
		chk({30'h0, conversion_busy, core_acq_run}, 32'h3);
		wr(OFF_CONTROL, 32'h0000_0010);
		chk({30'h0, conversion_busy, core_acq_run}, 32'h0);
		rd(OFF_OFFSET, 32'h0003_0003);
		chk(offset_out, 32'h0003_0003);
		rd(OFF_RESULT, 32'hfffd_00fd);
		chk(settings_out, 32'h0004_080c);
	endtask
	task automatic results;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset_values();
		t_control_bits();
		t_conversion();
		t_soft_reset();
		t_continuous();
		results();
	end
	// cut a hang short
	initial begin
		#200000;
		miscompares++;
		results();
	end
endmodule // test_adc_control_register_bank
`default_nettype wire
